// [pcs_pkg.sv]
// Constants, field layout and helpers for the program-counter and data-address sampler
package pds_pkg;
    localparam int ADDR_W = 32;
    localparam int ADDRESS_SPACE_ID_W = 8;
    localparam int FIELD_W = 49;
    localparam int WORD_W = 2 * FIELD_W;
    localparam int CNT_W = 12;
    localparam int RATE_BASE_LOG2 = 5;
    localparam int REG_AW = 4;

    localparam logic [REG_AW-1:0] CTRL_OFFSET = 4'h0;
    localparam logic [REG_AW-1:0] PC_VIEW_OFFSET = 4'h4;
    localparam logic [REG_AW-1:0] STATUS_OFFSET = 4'h8;

    localparam int PC_EN_BIT = 5;
    localparam int RATE_LSB = 6;
    localparam int RATE_MSB = 8;
    localparam int PC_HAS_BIT = 9;
    localparam int DA_HAS_BIT = 10;
    localparam int DA_EN_BIT = 23;
    localparam int DA_QUAL_BIT = 24;
    localparam int NOASID_BIT = 25;
    localparam int MISS_ONLY_BIT = 26;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_WR_MASK = 32'h0780_01e0;

    localparam logic PC_SAMPLE_IMPL = 1'b1;
    localparam logic DA_SAMPLE_IMPL = 1'b1;

    // Field: bit 0 new flag, 32:1 address, 40:33 space id, 48:41 zero
    localparam int NEW_BIT = 0;
    localparam int FADDR_LSB = 1;
    localparam int FASID_LSB = FADDR_LSB + ADDR_W;

    function automatic logic [FIELD_W-1:0] pack_sample(input logic [ADDR_W-1:0] addr,
                                                       input logic [ADDRESS_SPACE_ID_W-1:0] address_space_id,
                                                       input logic noasid);
        pack_sample = {8'h00, (noasid ? 8'h00 : address_space_id), addr, 1'b1};
    endfunction

    function automatic logic [CNT_W-1:0] period_last(input logic [2:0] rate);
        period_last = CNT_W'((13'h1 << (RATE_BASE_LOG2 + int'(rate))) - 13'h1);
    endfunction
endpackage

// [pcs_sync.sv]
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module pds_sync
    import pds_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            meta <= '0;
            o_q <= '0;
        end
        else
        begin
            meta <= i_d;
            o_q <= meta;
        end
    end
endmodule

// [pcs_scan.sv]
// Test-clock side: sample shadow, scan register and new-flag clearing
`timescale 1ns/100ps
module pds_scan
    import pds_pkg::*;
(
    input wire logic i_tck,
    input wire logic i_arst_n,
    input wire logic i_tap_sel,
    input wire logic i_capture_dr,
    input wire logic i_shift_dr,
    input wire logic i_tdi,
    input wire logic i_req_tog,
    input wire logic [WORD_W-1:0] i_word,
    input wire logic i_pc_en,
    input wire logic i_da_en,
    output logic o_ack_tog,
    output logic o_clr_tog,
    output logic o_tdo
);
    logic req_s;
    logic [1:0] en_s;
    logic [FIELD_W-1:0] pc_shadow;
    logic [FIELD_W-1:0] da_shadow;
    logic [WORD_W-1:0] sr;
    logic load;
    logic capture;

    pds_sync #(.W(1)) u_req_sync (.i_clk(i_tck), .i_arst_n(i_arst_n), .i_d(i_req_tog), .o_q(req_s));
    pds_sync #(.W(2)) u_en_sync (.i_clk(i_tck), .i_arst_n(i_arst_n), .i_d({i_da_en, i_pc_en}), .o_q(en_s));

    assign load = req_s ^ o_ack_tog;
    assign capture = i_tap_sel & i_capture_dr;

    // Latest sample always overwrites; a load beats a same-edge clear
    always_ff @(posedge i_tck or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            pc_shadow <= '0;
            da_shadow <= '0;
            o_ack_tog <= 1'b0;
        end
        else if (load)
        begin
            pc_shadow <= i_word[FIELD_W-1:0];
            da_shadow <= i_word[WORD_W-1:FIELD_W];
            o_ack_tog <= req_s;
        end
        else if (capture)
        begin
            pc_shadow[NEW_BIT] <= 1'b0;
            da_shadow[NEW_BIT] <= 1'b0;
        end
    end

    // Read-out tells the core side the flag was cleared
    always_ff @(posedge i_tck or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_clr_tog <= 1'b0;
        else if (capture)
            o_clr_tog <= ~o_clr_tog;
    end

    // Only enabled fields sit in the chain, PC field lowest
    always_ff @(posedge i_tck or negedge i_arst_n)
    begin
        if (!i_arst_n)
            sr <= '0;
        else if (capture)
        begin
            case (en_s)
                2'b11: sr <= {da_shadow, pc_shadow};
                2'b01: sr <= {{FIELD_W{1'b0}}, pc_shadow};
                2'b10: sr <= {{FIELD_W{1'b0}}, da_shadow};
                default: sr <= '0;
            endcase
        end
        else if (i_tap_sel && i_shift_dr)
        begin
            if (en_s == 2'b11)
                sr <= {i_tdi, sr[WORD_W-1:1]};
            else
                sr <= {{FIELD_W{1'b0}}, i_tdi, sr[FIELD_W-1:1]};
        end
    end

    always_ff @(posedge i_tck or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_tdo <= 1'b0;
        else
            o_tdo <= (i_tap_sel && i_shift_dr) ? sr[1] : sr[0];
    end

    both_fields_a: assert property (@(posedge i_tck) disable iff (!i_arst_n)
        (capture && en_s == 2'b11 && !load) |=> (sr == {$past(da_shadow), $past(pc_shadow)}))
        else $error("both fields not captured PC-low");

    flag_clear_a: assert property (@(posedge i_tck) disable iff (!i_arst_n)
        (capture && !load) |=> (!pc_shadow[NEW_BIT] && !da_shadow[NEW_BIT] && o_clr_tog != $past(o_clr_tog)))
        else $error("read-out did not clear new flags");
endmodule

// [pcs_sampler.sv]
// Program-counter and data-address sampler with scan read-out
`timescale 1ns/100ps
// Notes on behaviour
// - Sample PC continuously when present and enabled
// - Newer sample overwrites unread older one
// - Period from rate field, debug control bits 8:6
// - Writing rate field restarts the counter
// - Sample holds flag, address, optional space id
// - Fresh sample sets flag; probe read clears
// - Graduating PC; stalled expiry takes next graduating
// - Sampling continues in debug mode
// - Only enabled fields; PC field lowest
// - Each field 49 bits long
// - Wait state: counter frozen, flag re-set while PC sampling is on
// - Miss-only mode samples latest missed fetch
// - Bit 23 enables data-address field
// - Qualified mode: only breakpoint 0 triggers
// - Same counter latches latest load/store address
// - Read-only bits report implemented features
module pds_sampler
    import pds_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [REG_AW-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_grad_valid,
    input wire logic [ADDR_W-1:0] i_grad_pc,
    input wire logic [ADDRESS_SPACE_ID_W-1:0] i_grad_address_space_id,
    input wire logic i_fetch_miss,
    input wire logic i_ls_valid,
    input wire logic [ADDR_W-1:0] i_ls_addr,
    input wire logic [ADDRESS_SPACE_ID_W-1:0] i_ls_address_space_id,
    input wire logic i_bp0_match,
    input wire logic i_bp0_trigger_enable,
    input wire logic i_wait_state,
    input wire logic i_tck,
    input wire logic i_tap_sel,
    input wire logic i_capture_dr,
    input wire logic i_shift_dr,
    input wire logic i_tdi,
    output logic o_tdo
);
    logic [31:0] debug_control_reg;
    logic [CNT_W-1:0] sample_rate_counter;
    logic [2:0] sample_rate_field;
    logic pc_sample_enable;
    logic data_sample_enable;
    logic data_sample_qualify;
    logic suppress_space_id;
    logic miss_only_sampling;
    logic pc_on;
    logic da_on;
    logic run;
    logic expire;
    logic ctrl_write;
    logic pc_pending;
    logic pc_take_live;
    logic pc_take_miss;
    logic [ADDR_W-1:0] miss_pc;
    logic [ADDRESS_SPACE_ID_W-1:0] miss_address_space_id;
    logic miss_seen;
    logic [ADDR_W-1:0] ls_addr;
    logic [ADDRESS_SPACE_ID_W-1:0] ls_address_space_id;
    logic ls_seen;
    logic ls_accept;
    logic da_take;
    logic [FIELD_W-1:0] pc_samp;
    logic [FIELD_W-1:0] da_samp;
    logic [WORD_W-1:0] xfer_word;
    logic req_tog;
    logic ack_tog_tck;
    logic ack_s;
    logic clr_tog_tck;
    logic clr_s;
    logic clr_q;
    logic clr_evt;
    logic wait_q;
    logic busy;
    logic dirty;
    logic send;
    logic renew;
    logic [31:0] ctrl_view;

    assign ctrl_write = i_wr && (i_addr == CTRL_OFFSET);
    assign sample_rate_field = debug_control_reg[RATE_MSB:RATE_LSB];
    assign pc_sample_enable = debug_control_reg[PC_EN_BIT];
    assign data_sample_enable = debug_control_reg[DA_EN_BIT];
    assign data_sample_qualify = debug_control_reg[DA_QUAL_BIT];
    assign suppress_space_id = debug_control_reg[NOASID_BIT];
    assign miss_only_sampling = debug_control_reg[MISS_ONLY_BIT];
    assign pc_on = PC_SAMPLE_IMPL & pc_sample_enable;
    assign da_on = DA_SAMPLE_IMPL & data_sample_enable;

    // Debug mode does not gate sampling; only the wait state freezes it
    assign run = (pc_on | da_on) & ~i_wait_state;
    assign expire = run && (sample_rate_counter == period_last(sample_rate_field));

    // Debug control register
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            debug_control_reg <= CTRL_RESET;
        else if (ctrl_write)
            debug_control_reg <= i_wdata & CTRL_WR_MASK;
    end

    // Sample counter
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            sample_rate_counter <= '0;
        else if (ctrl_write)
            sample_rate_counter <= '0;
        else if (expire)
            sample_rate_counter <= '0;
        else if (run)
            sample_rate_counter <= sample_rate_counter + CNT_W'(1);
    end

    // Expiry while no instruction graduates waits for the next one
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            pc_pending <= 1'b0;
        else if (!pc_on || miss_only_sampling)
            pc_pending <= 1'b0;
        else if (i_grad_valid)
            pc_pending <= 1'b0;
        else if (expire)
            pc_pending <= 1'b1;
    end

    assign pc_take_live = pc_on && !miss_only_sampling && i_grad_valid && (expire || pc_pending);
    assign pc_take_miss = pc_on && miss_only_sampling && expire && miss_seen;

    // Latest instruction whose fetch missed the cache
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            miss_pc <= '0;
            miss_address_space_id <= '0;
            miss_seen <= 1'b0;
        end
        else if (i_grad_valid && i_fetch_miss)
        begin
            miss_pc <= i_grad_pc;
            miss_address_space_id <= i_grad_address_space_id;
            miss_seen <= 1'b1;
        end
        else if (pc_take_miss)
            miss_seen <= 1'b0;
    end

    // Latest load/store address, optionally qualified by breakpoint 0
    assign ls_accept = i_ls_valid && (!data_sample_qualify || (i_bp0_match && i_bp0_trigger_enable));
    assign da_take = da_on && expire && ls_seen;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ls_addr <= '0;
            ls_address_space_id <= '0;
            ls_seen <= 1'b0;
        end
        else if (ls_accept)
        begin
            ls_addr <= i_ls_addr;
            ls_address_space_id <= i_ls_address_space_id;
            ls_seen <= 1'b1;
        end
        else if (da_take)
            ls_seen <= 1'b0;
    end

    // Sample fields; new flag is always set in a stored sample
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            pc_samp <= '0;
        else if (pc_take_live)
            pc_samp <= pack_sample(i_grad_pc, i_grad_address_space_id, suppress_space_id);
        else if (pc_take_miss)
            pc_samp <= pack_sample(miss_pc, miss_address_space_id, suppress_space_id);
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            da_samp <= '0;
        else if (da_take)
            da_samp <= pack_sample(ls_addr, ls_address_space_id, suppress_space_id);
    end

    // Probe-clear events from the test-clock side
    pds_sync #(.W(2)) u_back_sync
    (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_d({clr_tog_tck, ack_tog_tck}),
        .o_q({clr_s, ack_s})
    );

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            clr_q <= 1'b0;
            wait_q <= 1'b0;
        end
        else
        begin
            clr_q <= clr_s;
            wait_q <= i_wait_state;
        end
    end

    assign clr_evt = clr_s ^ clr_q;
    // In wait, with PC sampling on, the flag is re-set after each probe clear by resending
    assign renew = i_wait_state && pc_on && pc_samp[NEW_BIT] && (clr_evt || !wait_q);

    // Handshake: word held stable until acknowledged
    assign busy = req_tog ^ ack_s;
    assign send = dirty && !busy;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            dirty <= 1'b0;
        else if (pc_take_live || pc_take_miss || da_take || renew)
            dirty <= 1'b1;
        else if (send)
            dirty <= 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            xfer_word <= '0;
            req_tog <= 1'b0;
        end
        else if (send)
        begin
            xfer_word <= {da_samp, pc_samp};
            req_tog <= ~req_tog;
        end
    end

    pds_scan u_scan
    (
        .i_tck(i_tck),
        .i_arst_n(i_arst_n),
        .i_tap_sel(i_tap_sel),
        .i_capture_dr(i_capture_dr),
        .i_shift_dr(i_shift_dr),
        .i_tdi(i_tdi),
        .i_req_tog(req_tog),
        .i_word(xfer_word),
        .i_pc_en(pc_on),
        .i_da_en(da_on),
        .o_ack_tog(ack_tog_tck),
        .o_clr_tog(clr_tog_tck),
        .o_tdo(o_tdo)
    );

    // Register read port
    always_comb
    begin
        ctrl_view = debug_control_reg;
        ctrl_view[PC_HAS_BIT] = PC_SAMPLE_IMPL;
        ctrl_view[DA_HAS_BIT] = DA_SAMPLE_IMPL;
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_rdata <= '0;
        else if (i_rd)
        begin
            case (i_addr)
                CTRL_OFFSET: o_rdata <= ctrl_view;
                PC_VIEW_OFFSET: o_rdata <= pc_samp[FADDR_LSB +: ADDR_W];
                STATUS_OFFSET: o_rdata <= {27'h0, busy, dirty, ls_seen, miss_seen, pc_pending};
                default: o_rdata <= '0;
            endcase
        end
        else
            o_rdata <= '0;
    end

    rate_restart_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        ctrl_write |=> (sample_rate_counter == '0))
        else $error("rate write did not restart counter");

    wait_freeze_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_wait_state && !ctrl_write) |=> $stable(sample_rate_counter))
        else $error("counter advanced in wait state");

    count_step_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (run && !ctrl_write && sample_rate_counter != period_last(sample_rate_field))
        |=> (sample_rate_counter == $past(sample_rate_counter) + CNT_W'(1)))
        else $error("counter did not step toward period");

    pc_capture_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        pc_take_live |=> (pc_samp[FADDR_LSB +: ADDR_W] == $past(i_grad_pc) && pc_samp[NEW_BIT]))
        else $error("graduating PC not captured");

    stall_wait_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (pc_on && !miss_only_sampling && expire && !i_grad_valid && !ctrl_write) |=> pc_pending)
        else $error("stalled expiry not held pending");

    space_id_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (pc_take_live && suppress_space_id) |=> (pc_samp[FASID_LSB +: ADDRESS_SPACE_ID_W] == 8'h00))
        else $error("space id not suppressed");

    miss_pc_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        pc_take_miss |=> (pc_samp[FADDR_LSB +: ADDR_W] == $past(miss_pc)))
        else $error("missed fetch PC not captured");

    qual_block_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (data_sample_qualify && !(i_bp0_match && i_bp0_trigger_enable)) |=> $stable(ls_addr))
        else $error("unqualified address recorded");

    da_latch_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        da_take |=> (da_samp[FADDR_LSB +: ADDR_W] == $past(ls_addr)))
        else $error("data address not latched on expiry");

    pc_off_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !pc_on |=> $stable(pc_samp))
        else $error("PC sampled while disabled");

    cap_bits_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_rd && i_addr == CTRL_OFFSET) |=> (o_rdata[PC_HAS_BIT] == PC_SAMPLE_IMPL && o_rdata[DA_HAS_BIT] == DA_SAMPLE_IMPL))
        else $error("capability bits wrong");

    da_off_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !da_on |=> $stable(da_samp))
        else $error("data address sampled while disabled");

    wait_renew_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_wait_state && pc_on && pc_samp[NEW_BIT] && clr_evt) |=> dirty)
        else $error("probe clear in wait not renewed");
endmodule

// [pcs_probe.sv]
// Debug probe model that shifts the sample scan register out over the test port
`timescale 1ns/100ps
module pds_probe
(
    output logic o_tck,
    output logic o_tap_sel,
    output logic o_capture_dr,
    output logic o_shift_dr,
    output logic o_tdi,
    input wire logic i_tdo
);
    initial
    begin
        o_tck = 1'b0;
        o_tap_sel = 1'b0;
        o_capture_dr = 1'b0;
        o_shift_dr = 1'b0;
        o_tdi = 1'b0;
    end

    // One frame: idle edges, capture, then len bits; test clock still outside frames
    task automatic scan(input int len, output logic [97:0] v);
        v = '0;
        #8 o_tap_sel = 1'b1;
        for (int i = -16; i < len; i++)
        begin
            #15;
            if (i >= 0)
                v[i] = i_tdo;
            #1 o_tck = 1'b1;
            o_capture_dr <= (i == -3);
            o_shift_dr <= (i >= -1) && (i < len - 1);
            o_tdi <= ~o_tdi;
            #16 o_tck = 1'b0;
        end
        o_tap_sel = 1'b0;
    endtask
endmodule

// [pcs_sampler_tb_top.sv]
// Self-checking bench for the program-counter and data-address sampler
`timescale 1ns/100ps
module pds_sampler_tb_top
    import pds_pkg::*;
();
    localparam logic [31:0] PE = 32'h1 << PC_EN_BIT;
    localparam logic [31:0] DE = 32'h1 << DA_EN_BIT;
    localparam logic [31:0] DQ = 32'h1 << DA_QUAL_BIT;
    localparam logic [31:0] NA = 32'h1 << NOASID_BIT;
    localparam logic [31:0] PM = 32'h1 << MISS_ONLY_BIT;
    localparam logic [31:0] CAP = (32'h1 << PC_HAS_BIT) | (32'h1 << DA_HAS_BIT);
    logic i_clk, i_arst_n, i_wr, i_rd, i_grad_valid, i_fetch_miss, i_ls_valid;
    logic i_bp0_match, i_bp0_trigger_enable, i_wait_state;
    logic i_tck, i_tap_sel, i_capture_dr, i_shift_dr, i_tdi, o_tdo;
    logic [REG_AW-1:0] i_addr;
    logic [31:0] i_wdata, o_rdata, i_grad_pc, i_ls_addr, rd_val;
    logic [7:0] i_grad_address_space_id, i_ls_address_space_id;
    logic [97:0] sv;
    int error_cnt = 0;
    int cmp_count = 0;

    pds_sampler DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_grad_valid(i_grad_valid), .i_grad_pc(i_grad_pc),
        .i_grad_address_space_id(i_grad_address_space_id), .i_fetch_miss(i_fetch_miss), .i_ls_valid(i_ls_valid), .i_ls_addr(i_ls_addr),
        .i_ls_address_space_id(i_ls_address_space_id), .i_bp0_match(i_bp0_match), .i_bp0_trigger_enable(i_bp0_trigger_enable),
        .i_wait_state(i_wait_state), .i_tck(i_tck), .i_tap_sel(i_tap_sel), .i_capture_dr(i_capture_dr),
        .i_shift_dr(i_shift_dr), .i_tdi(i_tdi), .o_tdo(o_tdo));

    pds_probe PROBE (.o_tck(i_tck), .o_tap_sel(i_tap_sel), .o_capture_dr(i_capture_dr),
        .o_shift_dr(i_shift_dr), .o_tdi(i_tdi), .i_tdo(o_tdo));

    initial
    begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    function automatic logic [48:0] fld(input logic [31:0] a, input logic [7:0] s);
        fld = {8'h00, s, a, 1'b1};
    endfunction

    task automatic chk(input logic [97:0] got, input logic [97:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        rd_val = o_rdata;
    endtask

    task automatic ls(input logic [31:0] a, input logic m, input logic te);
        @(posedge i_clk);
        i_ls_valid <= 1'b1;
        i_ls_addr <= a;
        i_bp0_match <= m;
        i_bp0_trigger_enable <= te;
        @(posedge i_clk);
        i_ls_valid <= 1'b0;
    endtask

    task automatic t_regs;
        rd(CTRL_OFFSET);
        chk(rd_val, CAP);
        wr(CTRL_OFFSET, 32'hffff_ffff);
        wr(4'hc, 32'hffff_ffff);
        rd(CTRL_OFFSET);
        chk(rd_val, CTRL_WR_MASK | CAP);
        rd(4'hc);
        chk(rd_val, 32'h0);
        wr(CTRL_OFFSET, 32'h0);
        PROBE.scan(49, sv);
        chk(sv, 98'h0);
    endtask

    task automatic t_rates;
        logic [31:0] last;
        last = 32'h0;
        for (int k = 0; k < 8; k++)
        begin
            wr(CTRL_OFFSET, PE | (32'(k) << RATE_LSB));
            i_grad_pc <= 32'h1000_0000 + 32'(k << 4);
            repeat ((32 << k) - 5) @(posedge i_clk);
            rd(PC_VIEW_OFFSET);
            chk(rd_val, last);
            repeat (6) @(posedge i_clk);
            rd(PC_VIEW_OFFSET);
            last = 32'h1000_0000 + 32'(k << 4);
            chk(rd_val, last);
        end
        repeat (20) @(posedge i_clk);
        PROBE.scan(49, sv);
        chk(sv, fld(last, 8'h3c));
        PROBE.scan(49, sv);
        chk(sv, fld(last, 8'h3c) ^ 49'h1);
    endtask

    task automatic t_both;
        wr(CTRL_OFFSET, PE | DE | NA);
        ls(32'h2000_0010, 1'b0, 1'b0);
        ls(32'h2000_0020, 1'b0, 1'b0);
        repeat (36) @(posedge i_clk);
        PROBE.scan(98, sv);
        chk(sv, {fld(32'h2000_0020, 8'h00), fld(i_grad_pc, 8'h00)});
        wr(CTRL_OFFSET, PE | DE | NA);
        ls(32'h2000_0030, 1'b0, 1'b0);
        repeat (36) @(posedge i_clk);
        PROBE.scan(98, sv);
        chk(sv[97:49], fld(32'h2000_0030, 8'h00));
    endtask

    task automatic t_qual;
        wr(CTRL_OFFSET, DE | DQ);
        ls(32'h3000_0040, 1'b1, 1'b1);
        ls(32'h3000_0050, 1'b1, 1'b0);
        ls(32'h3000_0060, 1'b0, 1'b1);
        repeat (36) @(posedge i_clk);
        PROBE.scan(49, sv);
        chk(sv, fld(32'h3000_0040, 8'h5a));
    endtask

    task automatic t_miss_stall;
        wr(CTRL_OFFSET, PE | PM);
        i_grad_pc <= 32'h4000_0100;
        i_fetch_miss <= 1'b1;
        @(posedge i_clk);
        i_grad_pc <= 32'h4000_0200;
        i_fetch_miss <= 1'b0;
        repeat (40) @(posedge i_clk);
        rd(PC_VIEW_OFFSET);
        chk(rd_val, 32'h4000_0100);
        wr(CTRL_OFFSET, PE);
        i_grad_valid <= 1'b0;
        i_grad_pc <= 32'h5000_0000;
        repeat (40) @(posedge i_clk);
        rd(PC_VIEW_OFFSET);
        chk(rd_val, 32'h4000_0100);
        @(posedge i_clk);
        i_grad_valid <= 1'b1;
        @(posedge i_clk);
        i_grad_pc <= 32'h5000_0100;
        repeat (4) @(posedge i_clk);
        rd(PC_VIEW_OFFSET);
        chk(rd_val, 32'h5000_0000);
    endtask

    task automatic t_wait;
        wr(CTRL_OFFSET, PE);
        i_grad_pc <= 32'h6000_0000;
        repeat (40) @(posedge i_clk);
        i_wait_state <= 1'b1;
        i_grad_pc <= 32'h6000_0100;
        repeat (5) @(posedge i_clk);
        repeat (2)
        begin
            PROBE.scan(49, sv);
            chk(sv, fld(32'h6000_0000, 8'h3c));
        end
        @(posedge i_clk);
        i_wait_state <= 1'b0;
        repeat (70) @(posedge i_clk);
        PROBE.scan(49, sv);
        chk(sv, fld(32'h6000_0100, 8'h3c));
    endtask

    task automatic results;
        $display("Checks %0d, errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        i_arst_n = 1'b0;
        {i_wr, i_rd, i_fetch_miss, i_ls_valid, i_bp0_match, i_bp0_trigger_enable, i_wait_state} = '0;
        i_grad_valid = 1'b1;
        i_addr = '0;
        i_wdata = '0;
        i_grad_pc = '0;
        i_ls_addr = '0;
        i_grad_address_space_id = 8'h3c;
        i_ls_address_space_id = 8'h5a;
        repeat (12) @(posedge i_clk);
        i_arst_n <= 1'b1;
        t_regs;
        t_rates;
        t_both;
        t_qual;
        t_miss_stall;
        t_wait;
        results;
    end

    // Whole sequence needs well under a millisecond
    initial
    begin
        #2000000;
        error_cnt++;
        results;
    end
endmodule
